// >>> design/pse_regs.sv
// Status and fault register bank of the pulse controller
`timescale 1ns/100ps

module pse_regs
    import pse_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire pse_pkg::pse_cmd_type      cmd,
    input  wire pse_pkg::pse_devstate_type devState,
    input  wire pse_pkg::pse_sense_type    sense,
    input  wire logic                      extTrigger,
    output logic                           cmdReady_r,
    output logic                           rspValid_r,
    output logic                           rspRefused_r,
    output logic [31:0]                    rspData_r,
    output logic                           laserEnable_r,
    output logic                           voltOrCurrentSelect_r,
    output logic                           emitGate_r,
    output logic                           shotStart_r
);

`include "pse_defines.svh"

    // ****************************************************************
    // Status word assembly
    // ****************************************************************
    // Shared by read and write answers so both show the same layout
    function automatic logic [31:0] buildStatus(
        input logic [31:0]      rw,
        input pse_devstate_type ds
    );
        logic [31:0] s;
        s = rw & `PSE_ST_WR_MASK;
        s[`PSE_ST_MODE]   = ds.freqGenMode;
        s[`PSE_ST_CALRUN] = ds.calibrationRunning;
        s[`PSE_ST_BUSY]   = ds.busy;
        s[`PSE_ST_INIT]   = ds.initComplete;
        s[`PSE_ST_DEVCHG] = ds.deviceChanged;
        return s;
    endfunction

    // Faults that force the output off
    function automatic logic stopsOutput(input logic [31:0] f);
        return |(f & ~`PSE_FL_NOSTOP);
    endfunction

    // ****************************************************************
    // Pin synchroniser for the external trigger
    // ****************************************************************
    logic trigMeta_r;
    logic trigSync_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trigMeta_r <= 1'b0;
            trigSync_r <= 1'b0;
        end else begin
            trigMeta_r <= extTrigger;
            trigSync_r <= trigMeta_r;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [31:0] statusRw_r;
    logic [31:0] statusRwNxt;
    logic [31:0] fault_r;
    logic [31:0] faultNxt;
    logic [31:0] faultRaw;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic cmdTaken;
    logic cmdIgnored;
    logic doWrite;
    logic doClear;
    logic doReadStatus;
    logic doReadFault;

    // Commands are ignored while the device reports itself busy
    assign cmdTaken     = cmd.valid & ~devState.busy;
    assign cmdIgnored   = cmd.valid & devState.busy;
    assign doWrite      = cmdTaken & (cmd.op == write_status_cmd);
    assign doClear      = cmdTaken & (cmd.op == clear_fault_cmd);
    assign doReadStatus = cmdTaken & (cmd.op == read_status_cmd);
    assign doReadFault  = cmdTaken & (cmd.op == read_fault_cmd);

    // ****************************************************************
    // Fault sources
    // ****************************************************************
    logic overCurrent;
    logic cpuOverheat;
    logic overcurrentTrip;
    logic controllerOverheat;
    logic driverHeatWarning;
    logic driverHeatCutoff;
    logic driverCoolingPhase;
    logic driverSensorBroken;
    logic driverDefective;
    logic driverAbsent;
    logic calibrationFault;
    logic driverDataMissing;
    logic supplyLow;
    logic internalFault;
    logic driverIdInvalid;

    assign overCurrent = sense.currentValid &
                         (sense.pulseCurrent > sense.currentLimit);
    assign cpuOverheat = sense.controllerTemp > `PSE_CPU_TEMP_MAX;

    // One named wire per cause keeps the bit map in a single place
    assign overcurrentTrip    = sense.faultEvent[`PSE_FL_OVERCUR] |
                                overCurrent;
    assign controllerOverheat = sense.faultEvent[`PSE_FL_CPUHOT] |
                                cpuOverheat;
    assign driverHeatWarning  = sense.faultEvent[`PSE_FL_HEATWARN];
    assign driverHeatCutoff   = sense.faultEvent[`PSE_FL_HEATCUT];
    assign driverCoolingPhase = sense.faultEvent[`PSE_FL_COOLING];
    assign driverSensorBroken = sense.faultEvent[`PSE_FL_SENSOR];
    assign driverDefective    = sense.faultEvent[`PSE_FL_DEFECT];
    assign driverAbsent       = sense.faultEvent[`PSE_FL_ABSENT];
    assign calibrationFault   = sense.faultEvent[`PSE_FL_CALFAULT];
    assign driverDataMissing  = sense.faultEvent[`PSE_FL_DATAMISS];
    assign supplyLow          = sense.faultEvent[`PSE_FL_SUPPLY];
    assign internalFault      = sense.faultEvent[`PSE_FL_INTERNAL];
    assign driverIdInvalid    = sense.faultEvent[`PSE_FL_BADID];

    // Unmapped event bits are dropped here, so reserved bits stay zero
    always_comb begin
        faultRaw = 32'h0000_0000;
        faultRaw[`PSE_FL_OVERCUR]  = overcurrentTrip;
        faultRaw[`PSE_FL_CPUHOT]   = controllerOverheat;
        faultRaw[`PSE_FL_HEATWARN] = driverHeatWarning;
        faultRaw[`PSE_FL_HEATCUT]  = driverHeatCutoff;
        faultRaw[`PSE_FL_COOLING]  = driverCoolingPhase;
        faultRaw[`PSE_FL_SENSOR]   = driverSensorBroken;
        faultRaw[`PSE_FL_DEFECT]   = driverDefective;
        faultRaw[`PSE_FL_ABSENT]   = driverAbsent;
        faultRaw[`PSE_FL_CALFAULT] = calibrationFault;
        faultRaw[`PSE_FL_DATAMISS] = driverDataMissing;
        faultRaw[`PSE_FL_SUPPLY]   = supplyLow;
        faultRaw[`PSE_FL_INTERNAL] = internalFault;
        faultRaw[`PSE_FL_BADID]    = driverIdInvalid;
    end

    // ****************************************************************
    // Sticky fault bits
    // ****************************************************************
    // A new event in the clearing cycle wins, so no fault is lost
    localparam logic [31:0] PERSIST = `PSE_FL_PERSIST;
    localparam logic [31:0] VALID   = `PSE_FL_VALID_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : gFault
            logic dropBit;
            assign dropBit = doClear & ~PERSIST[gi];
            assign faultNxt[gi] = VALID[gi] &
                                  (faultRaw[gi] |
                                   (fault_r[gi] & ~dropBit));
        end
    endgenerate

    // ****************************************************************
    // Status write path
    // ****************************************************************
    logic faultPresent;
    logic criticalNxt;
    logic onRequest;
    logic switchOnBarred;

    // Any fault, stopping or not, bars a restart until it is cleared
    assign faultPresent = |faultNxt;
    assign criticalNxt  = stopsOutput(faultNxt);
    assign onRequest    = doWrite ? cmd.data[`PSE_ST_ON]
                                  : statusRw_r[`PSE_ST_ON];
    assign switchOnBarred = doWrite & cmd.data[`PSE_ST_ON] &
                            ~statusRw_r[`PSE_ST_ON] & faultPresent;

    always_comb begin
        statusRwNxt = statusRw_r;
        if (doWrite) begin
            // Whole word replaces the writable fields at once
            statusRwNxt = cmd.data & `PSE_ST_WR_MASK;
        end
        // Stopping faults also drop a switch that was already on
        if (switchOnBarred) begin
            statusRwNxt[`PSE_ST_ON] = 1'b0;
        end else if (criticalNxt) begin
            statusRwNxt[`PSE_ST_ON] = 1'b0;
        end else begin
            statusRwNxt[`PSE_ST_ON] = onRequest;
        end
    end

    // ****************************************************************
    // Answer selection
    // ****************************************************************
    logic [31:0] statusAnswer;
    logic [31:0] faultAnswer;
    logic [31:0] answerWord;
    logic        answerLoad;

    // Status answers show the word as it stands after the command
    assign statusAnswer = buildStatus(statusRwNxt, devState);
    assign faultAnswer  = faultNxt & `PSE_FL_VALID_MASK;
    assign answerLoad   = doWrite | doReadStatus | doReadFault | doClear;
    assign answerWord   = (doWrite | doReadStatus) ? statusAnswer
                                                   : faultAnswer;

    // ****************************************************************
    // Emission control
    // ****************************************************************
    logic laserEnableNxt;

    // Output is live only when switched on and no stopping fault stands
    assign laserEnableNxt = statusRwNxt[`PSE_ST_ON] & ~criticalNxt;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            statusRw_r <= `PSE_ST_RESET;
            fault_r    <= `PSE_FL_RESET;
        end else begin
            statusRw_r <= statusRwNxt;
            fault_r    <= faultNxt;
        end
    end

    // Handshake flags answer one cycle after the command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmdReady_r   <= 1'b0;
            rspValid_r   <= 1'b0;
            rspRefused_r <= 1'b0;
        end else begin
            cmdReady_r   <= ~devState.busy;
            rspValid_r   <= cmdTaken;
            rspRefused_r <= cmdIgnored;
        end
    end

    // Answer word holds until the next taken command
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rspData_r <= 32'h0000_0000;
        end else if (answerLoad) begin
            rspData_r <= answerWord;
        end
    end

    // Driver controls follow the status word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            laserEnable_r         <= 1'b0;
            voltOrCurrentSelect_r <= 1'b0;
        end else begin
            laserEnable_r         <= laserEnableNxt;
            voltOrCurrentSelect_r <= statusRwNxt[`PSE_ST_VOLT];
        end
    end

    // ****************************************************************
    // Trigger handling
    // ****************************************************************
    logic [3:0] triggerSelect;

    assign triggerSelect = statusRw_r[`PSE_ST_TRG_MSB:`PSE_ST_TRG_LSB];

    pse_trigger uTrigger (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .trigLevel     (trigSync_r),
        .triggerSelect (triggerSelect),
        .outputAllowed (laserEnable_r),
        .emitGate_r    (emitGate_r),
        .shotStart_r   (shotStart_r)
    );

endmodule

// >>> include/pse_defines.svh
// Field positions, masks, limits, trigger encodings and reset values of the pulse status bank
`ifndef PSE_DEFINES_SVH
`define PSE_DEFINES_SVH

// ****************************************************************
// Status word fields
// ****************************************************************
`define PSE_ST_ON          0
`define PSE_ST_MODE        1
`define PSE_ST_TRG_LSB     2
`define PSE_ST_TRG_MSB     5
`define PSE_ST_AUX         6
`define PSE_ST_FBMON       7
`define PSE_ST_VOLT        8
`define PSE_ST_CALMISS     9
`define PSE_ST_CALRUN      10
`define PSE_ST_BUSY        12
`define PSE_ST_INIT        13
`define PSE_ST_DEVCHG      14
`define PSE_ST_WR_MASK     32'h0000_03FD
`define PSE_ST_RESET       32'h0000_0000

// ****************************************************************
// Fault word fields
// ****************************************************************
`define PSE_FL_OVERCUR     0
`define PSE_FL_CPUHOT      3
`define PSE_FL_HEATWARN    5
`define PSE_FL_HEATCUT     6
`define PSE_FL_COOLING     7
`define PSE_FL_SENSOR      8
`define PSE_FL_DEFECT      9
`define PSE_FL_ABSENT      10
`define PSE_FL_CALFAULT    11
`define PSE_FL_DATAMISS    12
`define PSE_FL_SUPPLY      15
`define PSE_FL_INTERNAL    16
`define PSE_FL_BADID       17
`define PSE_FL_VALID_MASK  32'h0003_9FE9
`define PSE_FL_PERSIST     32'h0000_9200
`define PSE_FL_NOSTOP      32'h0000_0420
`define PSE_FL_RESET       32'h0000_0000

// ****************************************************************
// Limits and trigger encodings
// ****************************************************************
`define PSE_CPU_TEMP_MAX   8'd80
`define PSE_TRG_FALL       4'h0
`define PSE_TRG_RISE       4'h1
`define PSE_TRG_INT_A      4'h2
`define PSE_TRG_INT_B      4'h3
`define PSE_TRG_LOW        4'h4
`define PSE_TRG_HIGH       4'h5

`endif

// >>> include/pse_pkg.sv
// Types shared by the pulse status and fault register bank
package pse_pkg;

    typedef enum logic [1:0] {
        read_status_cmd,
        write_status_cmd,
        read_fault_cmd,
        clear_fault_cmd
    } pse_op_type;

    typedef struct packed {
        logic       valid;
        pse_op_type op;
        logic [31:0] data;
    } pse_cmd_type;

    typedef struct packed {
        logic freqGenMode;
        logic calibrationRunning;
        logic busy;
        logic initComplete;
        logic deviceChanged;
    } pse_devstate_type;

    typedef struct packed {
        logic [11:0] pulseCurrent;
        logic [11:0] currentLimit;
        logic        currentValid;
        logic [7:0]  controllerTemp;
        logic [31:0] faultEvent;
    } pse_sense_type;

endpackage

// >>> design/pse_trigger.sv
// Trigger mode decoder producing the emission gate and shot start pulse
`timescale 1ns/100ps

module pse_trigger
    import pse_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       trigLevel,
    input  wire logic [3:0] triggerSelect,
    input  wire logic       outputAllowed,
    output logic            emitGate_r,
    output logic            shotStart_r
);

`include "pse_defines.svh"

    logic trigPrev_r;
    logic riseSeen;
    logic fallSeen;
    logic gateNxt;
    logic startNxt;

    assign riseSeen = trigLevel & ~trigPrev_r;
    assign fallSeen = ~trigLevel & trigPrev_r;

    always_comb begin
        gateNxt  = 1'b0;
        startNxt = 1'b0;
        case (triggerSelect)
            `PSE_TRG_FALL:  startNxt = fallSeen;
            `PSE_TRG_RISE:  startNxt = riseSeen;
            `PSE_TRG_INT_A: gateNxt  = 1'b1;
            `PSE_TRG_INT_B: gateNxt  = 1'b1;
            `PSE_TRG_LOW:   gateNxt  = ~trigLevel;
            `PSE_TRG_HIGH:  gateNxt  = trigLevel;
            default: begin
                gateNxt  = 1'b0;
                startNxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trigPrev_r  <= 1'b0;
            emitGate_r  <= 1'b0;
            shotStart_r <= 1'b0;
        end else begin
            trigPrev_r  <= trigLevel;
            emitGate_r  <= gateNxt & outputAllowed;
            shotStart_r <= startNxt & outputAllowed;
        end
    end

endmodule

// >>> test/pse_regs_assertions.sv
// Port checker for the pulse status and fault register bank
`timescale 1ns/100ps
module pse_regs_assertions
    import pse_pkg::*;
(
    input wire logic                     sys_clk,
    input wire logic                     rst,
    input wire pse_pkg::pse_cmd_type      cmd,
    input wire pse_pkg::pse_devstate_type devState,
    input wire pse_pkg::pse_sense_type    sense,
    input wire logic                     extTrigger,
    input wire logic                     cmdReady_r,
    input wire logic                     rspValid_r,
    input wire logic                     rspRefused_r,
    input wire logic [31:0]              rspData_r,
    input wire logic                     laserEnable_r,
    input wire logic                     voltOrCurrentSelect_r,
    input wire logic                     emitGate_r,
    input wire logic                     shotStart_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire taken = cmd.valid && !devState.busy;
    wire isWr  = taken && cmd.op == write_status_cmd;
    wire oc    = sense.currentValid && sense.pulseCurrent > sense.currentLimit;
    wire hot   = sense.controllerTemp > 8'h50;
    property p_ans; taken |=> rspValid_r && !rspRefused_r; endproperty
    a_ans: assert property (p_ans) else $error("answer missing");
    property p_ref; cmd.valid && devState.busy |=> rspRefused_r && !rspValid_r;
    endproperty
    a_ref: assert property (p_ref) else $error("busy not refused");
    property p_sres;
        taken && cmd.op == read_status_cmd |=> !(|(rspData_r & 32'hFFFF_8800));
    endproperty
    a_sres: assert property (p_sres) else $error("status reserved");
    property p_fres;
        taken && cmd.op == read_fault_cmd |=> !(|(rspData_r & 32'hFFFC_6016));
    endproperty
    a_fres: assert property (p_fres) else $error("fault reserved");
    property p_off; isWr && !cmd.data[0] |=> !rspData_r[0] && !laserEnable_r;
    endproperty
    a_off: assert property (p_off) else $error("switch off");
    property p_fld;
        isWr |=> rspData_r[9:2] == $past(cmd.data[9:2])
            && voltOrCurrentSelect_r == $past(cmd.data[8]);
    endproperty
    a_fld: assert property (p_fld) else $error("write fields");
    property p_oc; oc || hot |=> !laserEnable_r; endproperty
    a_oc: assert property (p_oc) else $error("trip not stopping");
    property p_stop; |(sense.faultEvent & 32'h0003_9BC9) |=> !laserEnable_r;
    endproperty
    a_stop: assert property (p_stop) else $error("fault not stopping");
    property p_clr;
        taken && cmd.op == clear_fault_cmd && !oc && !hot
            && !(|sense.faultEvent) |=> !(|(rspData_r & 32'hFFFF_6DFF));
    endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_on;
        $rose(laserEnable_r) |-> $past(isWr && cmd.data[0]);
    endproperty
    a_on: assert property (p_on) else $error("unasked restart");
    c_clr: cover property (taken && cmd.op == clear_fault_cmd);
    c_ref: cover property (rspRefused_r);
    c_gate: cover property (emitGate_r);
endmodule
bind pse_regs pse_regs_assertions u_pse_regs_assertions (.sys_clk(sys_clk),
    .rst(rst), .cmd(cmd), .devState(devState), .sense(sense),
    .extTrigger(extTrigger), .cmdReady_r(cmdReady_r),
    .rspValid_r(rspValid_r), .rspRefused_r(rspRefused_r),
    .rspData_r(rspData_r), .laserEnable_r(laserEnable_r),
    .voltOrCurrentSelect_r(voltOrCurrentSelect_r),
    .emitGate_r(emitGate_r), .shotStart_r(shotStart_r));

// >>> test/pse_host.sv
// Host model issuing status and fault commands
`timescale 1ns/100ps
module pse_host
    import pse_pkg::*;
(
    input wire logic             sys_clk,
    output pse_pkg::pse_cmd_type cmd,
    input wire logic             rspRefused_r,
    input wire logic [31:0]      rspData_r
);
    logic [31:0] lastData;
    logic        lastRefused;
    initial cmd = '0;
    // One whole word per command, strobe held for exactly one edge
    task automatic xfer(input pse_op_type op, input logic [31:0] d);
        @(negedge sys_clk);
        cmd <= '{1'b1, op, d};
        @(negedge sys_clk);
        cmd.valid <= 1'b0;
        lastData = rspData_r;
        lastRefused = rspRefused_r;
    endtask
    task automatic rmw(input logic [31:0] mask, input logic [31:0] val);
        xfer(read_status_cmd, 32'h0);
        xfer(write_status_cmd, (lastData & ~mask) | (val & mask));
    endtask
endmodule

// >>> test/pse_regs_bench.sv
// Self-checking bench for the pulse status and fault register bank
`timescale 1ns/100ps
module pse_regs_bench;
    import pse_pkg::*;
    logic             sys_clk = 1'b0;
    logic             rst;
    pse_cmd_type      cmd;
    pse_devstate_type devState;
    pse_sense_type    sense;
    pse_sense_type    calm;
    logic             extTrigger;
    logic             cmdReady_r, rspValid_r, rspRefused_r;
    logic [31:0]      rspData_r;
    logic             laserEnable_r, voltOrCurrentSelect_r;
    logic             emitGate_r, shotStart_r;
    int               n_errors = 0;
    int               compares = 0;
    logic [5:0]       rows [7] = '{6'h09, 6'h0D, 6'h11, 6'h12, 6'h17,
                                   6'h14, 6'h1A};
    int               bits [8] = '{0, 3, 6, 7, 8, 11, 16, 17};
    always #20 sys_clk = ~sys_clk;
    pse_regs u_pse_regs (.sys_clk(sys_clk), .rst(rst), .cmd(cmd),
        .devState(devState), .sense(sense), .extTrigger(extTrigger),
        .cmdReady_r(cmdReady_r), .rspValid_r(rspValid_r),
        .rspRefused_r(rspRefused_r), .rspData_r(rspData_r),
        .laserEnable_r(laserEnable_r),
        .voltOrCurrentSelect_r(voltOrCurrentSelect_r),
        .emitGate_r(emitGate_r), .shotStart_r(shotStart_r));
    pse_host u_pse_host (.sys_clk(sys_clk), .cmd(cmd),
        .rspRefused_r(rspRefused_r), .rspData_r(rspData_r));
    task automatic close_out;
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", w, e, g);
            n_errors++;
        end
    endtask
    task automatic cc(input pse_op_type o, input logic [31:0] d,
                      input logic [31:0] e, input string w);
        u_pse_host.xfer(o, d);
        chk({w, " valid"}, 32'h1, 32'(rspValid_r));
        chk(w, e, u_pse_host.lastData);
    endtask
    // Holds a sense pattern for one cycle, then returns to quiet inputs
    task automatic ev(input pse_sense_type s);
        @(negedge sys_clk);
        sense = s;
        @(negedge sys_clk);
        sense = calm;
    endtask
    task automatic trip(input logic [31:0] f);
        chk("enable", 32'h0, 32'(laserEnable_r));
        cc(read_fault_cmd, 32'h0, f, "fault");
        cc(clear_fault_cmd, 32'h0, 32'h0, "clear");
        cc(write_status_cmd, 32'h1, 32'h1, "restart");
    endtask
    // Two synchroniser flops plus the gate register, then a spare cycle
    task automatic gate(input logic e);
        repeat (4) @(negedge sys_clk);
        chk("gate", 32'(e), 32'(emitGate_r));
    endtask
    // Opposite level first, so the wanted edge is really made
    task automatic shot(input logic lvl);
        logic seen;
        logic early;
        seen = 1'b0;
        early = 1'b0;
        extTrigger = ~lvl;
        repeat (6) @(negedge sys_clk) if (shotStart_r === 1'b1) early = 1'b1;
        extTrigger = lvl;
        repeat (8) @(negedge sys_clk) if (shotStart_r === 1'b1) seen = 1'b1;
        chk("wrong edge", 32'h0, 32'(early));
        chk("shot", 32'h1, 32'(seen));
    endtask
    initial begin
        rst = 1'b1;
        devState = '0;
        calm = '{12'h0, 12'h800, 1'b1, 8'h19, 32'h0};
        sense = calm;
        extTrigger = 1'b0;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        cc(read_status_cmd, 32'h0, 32'h0, "status reset");
        cc(read_fault_cmd, 32'h0, 32'h0, "fault reset");
        cc(write_status_cmd, 32'hFFFF_FFFF, 32'h3FD, "write");
        chk("on", 32'h1, 32'(laserEnable_r));
        chk("volt", 32'h1, 32'(voltOrCurrentSelect_r));
        devState = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        cc(read_status_cmd, 32'h0, 32'h67FF, "dev bits");
        devState.busy = 1'b1;
        @(negedge sys_clk);
        chk("ready", 32'h0, 32'(cmdReady_r));
        u_pse_host.xfer(read_status_cmd, 32'h0);
        chk("refused", 32'h1, 32'(u_pse_host.lastRefused));
        chk("no answer", 32'h0, 32'(rspValid_r));
        devState = '0;
        u_pse_host.rmw(32'h0000_0101, 32'h0);
        chk("volt", 32'h0, 32'(voltOrCurrentSelect_r));
        cc(write_status_cmd, 32'h1, 32'h1, "on");
        ev('{12'h0, 12'h800, 1'b1, 8'h19, 32'h0000_0420});
        chk("nonstop", 32'h1, 32'(laserEnable_r));
        cc(read_fault_cmd, 32'h0, 32'h420, "fault");
        cc(write_status_cmd, 32'h0, 32'h0, "off");
        cc(write_status_cmd, 32'h1, 32'h0, "barred");
        cc(clear_fault_cmd, 32'h0, 32'h0, "clear");
        cc(write_status_cmd, 32'h1, 32'h1, "on");
        foreach (bits[i]) begin
            ev('{12'h0, 12'h800, 1'b1, 8'h19, 32'h1 << bits[i]});
            trip(32'h1 << bits[i]);
        end
        ev('{12'h800, 12'h800, 1'b1, 8'h50, 32'h0});
        cc(read_fault_cmd, 32'h0, 32'h0, "at limits");
        ev('{12'h801, 12'h800, 1'b1, 8'h19, 32'h0});
        trip(32'h1);
        ev('{12'h0, 12'h800, 1'b1, 8'h51, 32'h0});
        trip(32'h8);
        foreach (rows[i]) begin
            cc(write_status_cmd, {26'h0, rows[i][5:2], 2'h1},
               {26'h0, rows[i][5:2], 2'h1}, "mode");
            extTrigger = rows[i][1];
            gate(rows[i][0]);
        end
        cc(write_status_cmd, 32'h5, 32'h5, "rise mode");
        shot(1'b1);
        cc(write_status_cmd, 32'h1, 32'h1, "fall mode");
        shot(1'b0);
        ev('{12'h0, 12'h800, 1'b1, 8'h19, 32'h0000_9200});
        cc(clear_fault_cmd, 32'h0, 32'h9200, "persist");
        cc(write_status_cmd, 32'h1, 32'h0, "barred");
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk("ready", 32'h1, 32'(cmdReady_r));
        cc(read_fault_cmd, 32'h0, 32'h0, "power up");
        cc(read_status_cmd, 32'h0, 32'h0, "status reset");
        close_out();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        close_out();
    end
endmodule
